// *** lpw_pkg.sv ***
package lpw_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFF_MODE_CTRL  = 12'h000;
  localparam logic [11:0] OFF_START0     = 12'h004;
  localparam logic [11:0] OFF_START1     = 12'h008;
  localparam logic [11:0] OFF_BOD_CTRL   = 12'h00C;
  localparam logic [11:0] OFF_PWR_RUN    = 12'h010;
  localparam logic [11:0] OFF_BUS_CLK1   = 12'h014;
  localparam logic [11:0] OFF_STATUS     = 12'h018;
  localparam logic [11:0] OFF_WAKE_CAUSE = 12'h01C;

  // requested low power mode codes
  localparam logic [1:0] MODE_ACTIVE     = 2'h0;
  localparam logic [1:0] MODE_SLEEP      = 2'h1;
  localparam logic [1:0] MODE_DEEP_SLEEP = 2'h2;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DMA_KEEP = 2;
  localparam int BOD_IRQ_EN    = 0;
  localparam int BOD_RST_EN    = 1;
  localparam int PWR_WDT_OSC   = 0;
  localparam int PWR_BOD_KEEP  = 1;
  localparam int CLK1_MICRO_TICK_TIMER    = 0;
  localparam int ST_ALARM_BIT  = 3;
  localparam int ST_PDOWN_BIT  = 4;

  // interrupt line indices
  localparam int IRQ_N         = 18;
  localparam int PIN_N         = 8;
  localparam int IRQ_BOD       = 0;
  localparam int IRQ_WDT       = 1;
  localparam int IRQ_RTC_ALARM = 2;
  localparam int IRQ_RTC_WAKE  = 3;
  localparam int IRQ_MICRO_TICK_TIMER     = 4;
  localparam int IRQ_USART     = 5;
  localparam int IRQ_SPI       = 6;
  localparam int IRQ_I2C       = 7;
  localparam int IRQ_USB       = 8;
  localparam int IRQ_DMA       = 9;
  localparam int IRQ_PIN0      = 10;

  // reset values
  localparam logic [2:0]       RST_MODE_CTRL = 3'h0;
  localparam logic [IRQ_N-1:0] RST_START0    = 18'h00000;
  localparam logic [PIN_N-1:0] RST_START1    = 8'h00;
  localparam logic [1:0]       RST_BOD_CTRL  = 2'h0;
  localparam logic [1:0]       RST_PWR_RUN   = 2'h0;
  localparam logic [0:0]       RST_BUS_CLK1  = 1'h0;

  // clock restart settle time in pclk cycles
  localparam logic [2:0] WAKE_CYCLES = 3'h4;
endpackage

// *** sync2.sv ***
`timescale 1ns/1ps
// two flop synchroniser for asynchronous levels
module sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** rise_detect.sv ***
`timescale 1ns/1ps
// one cycle pulse on a rising level
module rise_detect (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level in, pulse out
  input  wire logic d,
  output logic      rise
);
  logic d_reg;

  // previous level and registered pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_reg <= 1'b0;
      rise  <= 1'b0;
    end else begin
      d_reg <= d;
      rise  <= d & ~d_reg;
    end
  end
endmodule

// *** low_power_wakeup_control.sv ***
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - deep power-down removes power from all but clock domain and reset pin
// - deep power-down exits only on reset pin or clock alarm/wake event
// - rising one-hertz alarm flag raises a clock alarm interrupt request
// - state is lost across deep power-down; config registers reinitialised on wake, wake cause kept
// - all functional pins go high impedance in deep power-down
// - deep-sleep stops serial clock; sync slave or 32 kHz mode still wakes
// - deep-sleep turns SPI and I2C off; slave mode interrupts still wake
// - DMA runs in deep-sleep only if configured; off in deep power-down
// - in sleep any controller-enabled interrupt wakes the processor
// - hardware wake request wakes from sleep and deep-sleep
// - pin interrupt wakes deep-sleep if controller and start enable 0/1 set
// - brownout wakes deep-sleep if all four enables hold
// - brownout resets in deep-sleep when its reset enable is set
// - watchdog interrupt wakes deep-sleep if oscillator, enables and feed hold
// - watchdog timeout resets if oscillator powered, enabled, reset option, fed
// - clock wake timer interrupt wakes when enabled in start enable 0
// - micro tick timer wakes with oscillator, clock, start and enable set
// - USB need-clock interrupt wakes from deep-sleep
// - deep-sleep stops main, peripheral and processor clocks; flash standby
module low_power_wakeup_control (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [lpw_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [lpw_pkg::DATA_W-1:0]   pwdata,
  output logic      [lpw_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // processor
  input  wire logic                         cpu_sleep_req,
  output logic                              cpu_clk_en,
  output logic                              wake_req,
  // interrupt controller
  input  wire logic [lpw_pkg::IRQ_N-1:0]    irq_pending,
  input  wire logic [lpw_pkg::IRQ_N-1:0]    nested_interrupt_controller_enable,
  // peripheral status, same clock
  input  wire logic                         bod_event,
  input  wire logic                         wdt_enabled,
  input  wire logic                         wdt_fed,
  input  wire logic                         wdt_int_en,
  input  wire logic                         wdt_reset_en,
  input  wire logic                         wdt_timeout,
  input  wire logic                         micro_tick_timer_running,
  input  wire logic                         usart_sync_slave,
  input  wire logic                         usart_32k_mode,
  input  wire logic                         spi_slave,
  input  wire logic                         i2c_slave,
  input  wire logic                         hardware_wake_request,
  // always-on domain, asynchronous
  input  wire logic                         reset_pin_n,
  input  wire logic                         alarm_one_hz_flag,
  input  wire logic                         clock_wake_irq,
  // power and clock controls
  output logic                              main_clk_en,
  output logic                              periph_clk_en,
  output logic                              usart_clk_en,
  output logic                              spi_i2c_clk_en,
  output logic                              dma_run_en,
  output logic                              flash_standby,
  output logic                              core_power_en,
  output logic                              pins_hiz,
  output logic                              clock_alarm_irq,
  output logic                              sys_reset_req,
  output logic      [2:0]                   power_state
);
  import lpw_pkg::*;

  typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_DEEP, ST_PDOWN, ST_WAKE} state_t;

  state_t           state_reg;
  state_t           state_next;
  logic [2:0]       mode_ctrl_reg;
  logic [IRQ_N-1:0] start0_reg;
  logic [PIN_N-1:0] start1_reg;
  logic [1:0]       bod_ctrl_reg;
  logic [1:0]       pwr_run_reg;
  logic [0:0]       bus_clk1_reg;
  logic [IRQ_N+2:0] wake_cause_reg;
  logic [IRQ_N+2:0] wake_cause_next;
  logic [2:0]       wake_cnt_reg;
  logic             from_pdown_reg;
  logic [2:0]       async_s;
  logic             pin_rst_s;
  logic             alarm_s;
  logic             ckwake_s;
  logic             alarm_rise;
  logic [IRQ_N-1:0] nv;
  logic [IRQ_N-1:0] deep_src;
  logic             sleep_wake;
  logic             deep_wake;
  logic             pdown_wake;
  logic             bod_rst;
  logic             wdt_rst;
  logic             reset_cause;
  logic             soft_clr;
  logic             wr_en;
  logic             rd_setup;
  logic             clk_run;

  // true when the offset names a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_MODE_CTRL, OFF_START0, OFF_START1, OFF_BOD_CTRL,
      OFF_PWR_RUN, OFF_BUS_CLK1, OFF_STATUS, OFF_WAKE_CAUSE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // always-on inputs cross into pclk
  sync2 #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({clock_wake_irq, alarm_one_hz_flag, reset_pin_n}),
    .q       (async_s)
  );

  assign pin_rst_s = ~async_s[0];
  assign alarm_s   = async_s[1];
  assign ckwake_s  = async_s[2];

  // alarm flag edge becomes the wake request
  rise_detect u_alarm_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (alarm_s),
    .rise    (alarm_rise)
  );

  // alarm interrupt request out
  assign clock_alarm_irq = alarm_rise;

  // interrupts enabled in the controller
  assign nv         = irq_pending & nested_interrupt_controller_enable;
  assign sleep_wake = (|nv) | hardware_wake_request;

  // deep-sleep qualification of each source
  always_comb begin
    deep_src = '0;
    for (int i = 0; i < PIN_N; i++) begin
      deep_src[IRQ_PIN0+i] = nv[IRQ_PIN0+i] &
                             (start0_reg[IRQ_PIN0+i] | start1_reg[i]);
    end
    deep_src[IRQ_BOD] = nv[IRQ_BOD] & start0_reg[IRQ_BOD] &
                        bod_ctrl_reg[BOD_IRQ_EN] & pwr_run_reg[PWR_BOD_KEEP];
    deep_src[IRQ_WDT] = nv[IRQ_WDT] & start0_reg[IRQ_WDT] &
                        pwr_run_reg[PWR_WDT_OSC] & wdt_enabled & wdt_fed &
                        wdt_int_en;
    deep_src[IRQ_RTC_ALARM] = (alarm_rise | irq_pending[IRQ_RTC_ALARM]) &
                              start0_reg[IRQ_RTC_ALARM];
    deep_src[IRQ_RTC_WAKE] = (ckwake_s | irq_pending[IRQ_RTC_WAKE]) &
                             start0_reg[IRQ_RTC_WAKE];
    deep_src[IRQ_MICRO_TICK_TIMER] = irq_pending[IRQ_MICRO_TICK_TIMER] & start0_reg[IRQ_MICRO_TICK_TIMER] &
                          pwr_run_reg[PWR_WDT_OSC] & bus_clk1_reg[CLK1_MICRO_TICK_TIMER] &
                          micro_tick_timer_running;
    deep_src[IRQ_USART] = irq_pending[IRQ_USART] &
                          (usart_sync_slave | usart_32k_mode);
    deep_src[IRQ_SPI] = irq_pending[IRQ_SPI] & spi_slave;
    deep_src[IRQ_I2C] = irq_pending[IRQ_I2C] & i2c_slave;
    deep_src[IRQ_USB] = irq_pending[IRQ_USB];
    deep_src[IRQ_DMA] = irq_pending[IRQ_DMA] & mode_ctrl_reg[CTRL_DMA_KEEP];
  end

  // merged wake per mode
  assign deep_wake  = (|deep_src) | hardware_wake_request;
  assign pdown_wake = alarm_rise | ckwake_s;

  // reset causes; detectors are unpowered in deep power-down
  assign bod_rst = bod_event & bod_ctrl_reg[BOD_RST_EN];
  assign wdt_rst = wdt_timeout & pwr_run_reg[PWR_WDT_OSC] & wdt_enabled &
                   wdt_fed & wdt_reset_en;
  assign reset_cause = pin_rst_s |
                       ((bod_rst | wdt_rst) & (state_reg != ST_PDOWN));

  // config discarded on restart from deep power-down
  assign soft_clr = (state_reg == ST_WAKE) & from_pdown_reg;

  // mode sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ACTIVE: begin
        if (cpu_sleep_req) begin
          unique case (mode_ctrl_reg[CTRL_MODE_LSB +: 2])
            MODE_SLEEP:      state_next = ST_SLEEP;
            MODE_DEEP_SLEEP: state_next = ST_DEEP;
            MODE_POWER_DOWN: state_next = ST_PDOWN;
            MODE_ACTIVE:     state_next = ST_ACTIVE;
          endcase
        end
      end
      ST_SLEEP: begin
        if (sleep_wake || reset_cause) begin
          state_next = ST_WAKE;
        end
      end
      ST_DEEP: begin
        if (deep_wake || reset_cause) begin
          state_next = ST_WAKE;
        end
      end
      ST_PDOWN: begin
        if (pdown_wake || pin_rst_s) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_cnt_reg == 3'h0) begin
          state_next = ST_ACTIVE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  // clock restart counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_reg <= 3'h0;
    end else if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
      wake_cnt_reg <= WAKE_CYCLES - 3'h1;
    end else if (wake_cnt_reg != 3'h0) begin
      wake_cnt_reg <= wake_cnt_reg - 3'h1;
    end
  end

  // remembers a restart from deep power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      from_pdown_reg <= 1'b0;
    end else if (state_reg == ST_PDOWN && state_next == ST_WAKE) begin
      from_pdown_reg <= 1'b1;
    end else if (state_next == ST_ACTIVE) begin
      from_pdown_reg <= 1'b0;
    end
  end

  // cause latched on leaving a low power mode
  always_comb begin
    wake_cause_next = wake_cause_reg;
    if (state_next == ST_WAKE && state_reg != ST_WAKE) begin
      wake_cause_next = {pin_rst_s, pdown_wake, hardware_wake_request,
                         (state_reg == ST_DEEP) ? deep_src : nv};
    end
  end

  // cause kept across restart for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cause_reg <= '0;
    end else begin
      wake_cause_reg <= wake_cause_next;
    end
  end

  // resume pulse and system reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req      <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      wake_req      <= (state_reg == ST_WAKE) & (state_next == ST_ACTIVE);
      sys_reset_req <= reset_cause | soft_clr;
    end
  end

  // clock, power and pin controls per state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en     <= 1'b1;
      main_clk_en    <= 1'b1;
      periph_clk_en  <= 1'b1;
      usart_clk_en   <= 1'b1;
      spi_i2c_clk_en <= 1'b1;
      dma_run_en     <= 1'b1;
      flash_standby  <= 1'b0;
      core_power_en  <= 1'b1;
      pins_hiz       <= 1'b0;
    end else begin
      cpu_clk_en     <= (state_next == ST_ACTIVE);
      main_clk_en    <= clk_run;
      periph_clk_en  <= clk_run;
      usart_clk_en   <= clk_run;
      spi_i2c_clk_en <= clk_run;
      dma_run_en     <= (state_next == ST_DEEP) ? mode_ctrl_reg[CTRL_DMA_KEEP] :
                        (state_next != ST_PDOWN);
      flash_standby  <= (state_next == ST_DEEP);
      core_power_en  <= (state_next != ST_PDOWN);
      pins_hiz       <= (state_next == ST_PDOWN);
    end
  end

  // state code and clock decode
  assign power_state = state_reg;
  assign clk_run     = (state_next != ST_DEEP) && (state_next != ST_PDOWN);

  // apb phases
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~is_mapped(paddr);

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl_reg <= RST_MODE_CTRL;
      start0_reg    <= RST_START0;
      start1_reg    <= RST_START1;
      bod_ctrl_reg  <= RST_BOD_CTRL;
      pwr_run_reg   <= RST_PWR_RUN;
      bus_clk1_reg  <= RST_BUS_CLK1;
    end else if (soft_clr) begin
      mode_ctrl_reg <= RST_MODE_CTRL;
      start0_reg    <= RST_START0;
      start1_reg    <= RST_START1;
      bod_ctrl_reg  <= RST_BOD_CTRL;
      pwr_run_reg   <= RST_PWR_RUN;
      bus_clk1_reg  <= RST_BUS_CLK1;
    end else if (wr_en) begin
      unique case (paddr)
        OFF_MODE_CTRL: mode_ctrl_reg <= pwdata[2:0];
        OFF_START0:    start0_reg    <= pwdata[IRQ_N-1:0];
        OFF_START1:    start1_reg    <= pwdata[PIN_N-1:0];
        OFF_BOD_CTRL:  bod_ctrl_reg  <= pwdata[1:0];
        OFF_PWR_RUN:   pwr_run_reg   <= pwdata[1:0];
        OFF_BUS_CLK1:  bus_clk1_reg  <= pwdata[0:0];
        default: ;
      endcase
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      unique case (paddr)
        OFF_MODE_CTRL:  prdata <= DATA_W'(mode_ctrl_reg);
        OFF_START0:     prdata <= DATA_W'(start0_reg);
        OFF_START1:     prdata <= DATA_W'(start1_reg);
        OFF_BOD_CTRL:   prdata <= DATA_W'(bod_ctrl_reg);
        OFF_PWR_RUN:    prdata <= DATA_W'(pwr_run_reg);
        OFF_BUS_CLK1:   prdata <= DATA_W'(bus_clk1_reg);
        OFF_STATUS:     prdata <= DATA_W'({from_pdown_reg, alarm_s, state_reg});
        OFF_WAKE_CAUSE: prdata <= DATA_W'(wake_cause_reg);
        default:        prdata <= '0;
      endcase
    end
  end
endmodule

// *** lpw_checker_sva.sv ***
`timescale 1ns/1ps
// mode output relations of the wake controller
module lpw_checker (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // always-on inputs
  input wire logic       alarm_one_hz_flag,
  input wire logic       clock_wake_irq,
  input wire logic       reset_pin_n,
  // mode outputs
  input wire logic       cpu_clk_en,
  input wire logic       wake_req,
  input wire logic       main_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       usart_clk_en,
  input wire logic       spi_i2c_clk_en,
  input wire logic       dma_run_en,
  input wire logic       flash_standby,
  input wire logic       core_power_en,
  input wire logic       pins_hiz,
  input wire logic       clock_alarm_irq,
  input wire logic [2:0] power_state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // power-down state and its outputs
  AST_PDOWN_PWR: assert property (power_state == 3'h3 |-> pins_hiz && !core_power_en)
    else $error("power-down pins or power");
  AST_PDOWN_DMA: assert property (power_state == 3'h3 |-> !dma_run_en)
    else $error("dma running in power-down");
  AST_PDOWN_HOLD: assert property ((power_state == 3'h3 && !alarm_one_hz_flag
    && !clock_wake_irq && reset_pin_n) [*4] |=> power_state == 3'h3)
    else $error("power-down left without cause");
  // deep-sleep clock gating
  AST_DEEP_CLK: assert property (power_state == 3'h2 |-> !main_clk_en && !periph_clk_en
    && flash_standby)
    else $error("deep-sleep clocks or flash");
  AST_DEEP_SER: assert property (power_state == 3'h2 |-> !usart_clk_en && !spi_i2c_clk_en)
    else $error("deep-sleep serial clocks");
  AST_CPU_CLK: assert property (cpu_clk_en == (power_state == 3'h0))
    else $error("core clock not active-only");
  // alarm request and resume pulses
  AST_ALARM_IRQ: assert property ($rose(alarm_one_hz_flag) |-> ##[2:4] clock_alarm_irq)
    else $error("no alarm request");
  AST_ALARM_ONE: assert property (clock_alarm_irq |=> !clock_alarm_irq)
    else $error("alarm request too long");
  AST_WAKE_LEN: assert property (power_state == 3'h4 && $past(power_state) != 3'h4 |->
    (power_state == 3'h4) [*4] ##1 (power_state == 3'h0 && wake_req))
    else $error("restart length wrong");
  AST_WAKE_ONE: assert property (wake_req |=> !wake_req)
    else $error("resume pulse too long");
endmodule

bind low_power_wakeup_control lpw_checker chk_u (
  .pclk, .presetn, .alarm_one_hz_flag, .clock_wake_irq, .reset_pin_n, .cpu_clk_en,
  .wake_req, .main_clk_en, .periph_clk_en, .usart_clk_en, .spi_i2c_clk_en, .dma_run_en,
  .flash_standby, .core_power_en, .pins_hiz, .clock_alarm_irq, .power_state
);

// *** lpw_partner.sv ***
`timescale 1ns/1ps
// peripheral, clock domain and reset pin sources raised on command
module lpw_partner (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // command: source code and delay
  input  wire logic                      fire,
  input  wire logic [4:0]                code,
  input  wire logic [3:0]                lag,
  input  wire logic                      wake_req,
  // sources
  output logic      [lpw_pkg::IRQ_N-1:0] irq_pending,
  output logic                           hardware_wake_request,
  output logic                           alarm_one_hz_flag,
  output logic                           clock_wake_irq,
  output logic                           reset_pin_n,
  output logic                           bod_event
);
  import lpw_pkg::*;
  logic [22:0] src_reg;
  logic [4:0]  code_reg;
  logic [3:0]  cnt_reg;
  logic        armed_reg;

  // source rises after the delay, stays until the core resumes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg   <= '0;
      armed_reg <= 1'h0;
      cnt_reg   <= '0;
      code_reg  <= '0;
    end else if (wake_req) begin
      src_reg   <= '0; // software clears the cause
      armed_reg <= 1'h0;
    end else if (fire) begin
      armed_reg <= 1'h1;
      cnt_reg   <= lag;
      code_reg  <= code;
    end else if (armed_reg && cnt_reg == 4'h0) begin
      src_reg[code_reg] <= 1'h1;
      armed_reg         <= 1'h0;
    end else if (armed_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  // source lines
  assign irq_pending           = src_reg[IRQ_N-1:0];
  assign hardware_wake_request = src_reg[18];
  assign alarm_one_hz_flag     = src_reg[19];
  assign clock_wake_irq        = src_reg[20];
  assign reset_pin_n           = ~src_reg[21];
  assign bod_event             = src_reg[22];
endmodule

// *** low_power_wakeup_control_tb_top.sv ***
`timescale 1ns/1ps
// drives the wake controller over apb and through the source model
module low_power_wakeup_control_tb_top;
  import lpw_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, fire;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              cpu_sleep_req, cpu_clk_en, wake_req, wdt_enabled, wdt_fed, wdt_int_en;
  logic              wdt_reset_en, wdt_timeout, micro_tick_timer_running, usart_sync_slave, usart_32k_mode;
  logic              spi_slave, i2c_slave, hardware_wake_request, reset_pin_n, bod_event;
  logic              alarm_one_hz_flag, clock_wake_irq, main_clk_en, periph_clk_en, usart_clk_en;
  logic              spi_i2c_clk_en, dma_run_en, flash_standby, core_power_en, pins_hiz;
  logic              clock_alarm_irq, sys_reset_req;
  logic [IRQ_N-1:0]  irq_pending, nested_interrupt_controller_enable;
  logic [2:0]        power_state;
  logic [4:0]        code;
  logic [3:0]        lag;
  logic [31:0]       r;
  logic [31:0]       seed = 32'h44FDDD80;
  logic [32:0]       exp_q[$];
  int                errors, samples_checked;

  low_power_wakeup_control dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_sleep_req, .cpu_clk_en, .wake_req, .irq_pending, .nested_interrupt_controller_enable, .bod_event,
    .wdt_enabled, .wdt_fed, .wdt_int_en, .wdt_reset_en, .wdt_timeout, .micro_tick_timer_running,
    .usart_sync_slave, .usart_32k_mode, .spi_slave, .i2c_slave, .hardware_wake_request,
    .reset_pin_n, .alarm_one_hz_flag, .clock_wake_irq, .main_clk_en, .periph_clk_en,
    .usart_clk_en, .spi_i2c_clk_en, .dma_run_en, .flash_standby, .core_power_en, .pins_hiz,
    .clock_alarm_irq, .sys_reset_req, .power_state
  );
  lpw_partner src_u (
    .pclk, .presetn, .fire, .code, .lag, .wake_req, .irq_pending, .hardware_wake_request,
    .alarm_one_hz_flag, .clock_wake_irq, .reset_pin_n, .bod_event
  );

  // 250 MHz clock
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, read expectation queued
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'h0, a, 32'h0, e);
  endtask

  // read completion against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check("read", exp_q.pop_front(), {pslverr, prdata});
  end

  task automatic wait_ps(input logic [2:0] s);
    for (int n = 0; n < 200 && power_state !== s; n++) @(posedge pclk);
    check("state", 33'(s), 33'(power_state));
  endtask

  task automatic enter(input logic [2:0] m);
    wr(OFF_MODE_CTRL, 32'(m));
    cpu_sleep_req <= 1'h1;
    @(posedge pclk);
    cpu_sleep_req <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic raise(input logic [4:0] c);
    fire <= 1'h1;
    code <= c;
    lag  <= 4'(xs());
    @(posedge pclk);
    fire <= 1'h0;
  endtask

  task automatic do_reset();
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, cpu_sleep_req, fire, wdt_reset_en, wdt_timeout} = '0;
    {wdt_enabled, wdt_fed, wdt_int_en, micro_tick_timer_running, usart_sync_slave, usart_32k_mode} = '0;
    {spi_slave, i2c_slave, paddr, pwdata, code, lag, nested_interrupt_controller_enable} = '0;
    do_reset();
    // reset values, unmapped word flagged
    for (int i = 0; i < 9; i++) rd(12'(4 * i), {i == 8, 32'h0});
    r = xs();
    wr(OFF_START0, r);
    rd(OFF_START0, {15'h0, r[17:0]});
    wr(OFF_STATUS, 32'hFFFFFFFF);
    rd(OFF_STATUS, 33'h0);
    enter(3'h0);
    check("no mode", 33'h8, 33'({cpu_clk_en, power_state}));
    // sleep: an enabled SPI interrupt resumes the core
    nested_interrupt_controller_enable <= '1;
    enter(3'h1);
    check("sleep", 33'h1, 33'({cpu_clk_en, power_state}));
    raise(5'h06);
    wait_ps(3'h4);
    wait_ps(3'h0);
    rd(OFF_WAKE_CAUSE, 33'h40);
    // deep-sleep: each qualified source wakes the part
    wr(OFF_START0, 32'h3FFFF);
    wr(OFF_BOD_CTRL, 32'h1);
    wr(OFF_PWR_RUN, 32'h3);
    wr(OFF_BUS_CLK1, 32'h1);
    {wdt_enabled, wdt_fed, wdt_int_en, micro_tick_timer_running, usart_32k_mode, spi_slave, i2c_slave} <= '1;
    for (int i = 0; i < 19; i++) begin
      enter(i == 9 ? 3'h6 : 3'h2);
      check("deep", {29'h1, i == 9, 3'h2}, 33'({main_clk_en, periph_clk_en, flash_standby,
            dma_run_en, power_state}));
      raise(5'(i));
      wait_ps(3'h4);
      wait_ps(3'h0);
      rd(OFF_WAKE_CAUSE, 33'h1 << i);
    end
    // pin waits for start enable 1
    wr(OFF_START0, 32'h0);
    enter(3'h2);
    raise(5'h0A);
    repeat (20) @(posedge pclk);
    check("pin held", 33'h2, 33'(power_state));
    wr(OFF_START1, 32'h1);
    wait_ps(3'h4);
    wait_ps(3'h0);
    rd(OFF_WAKE_CAUSE, 33'h400);
    // power-down: brownout ignored, clock domain wakes
    for (int k = 19; k < 21; k++) begin
      wr(OFF_BOD_CTRL, 32'h3);
      enter(3'h7);
      check("pdown", 33'h23, 33'({pins_hiz, core_power_en, dma_run_en, power_state}));
      raise(5'h16);
      repeat (20) @(posedge pclk);
      check("pdown hold", 33'h3, 33'({sys_reset_req, power_state}));
      raise(5'(k));
      wait_ps(3'h4);
      wait_ps(3'h0);
      rd(OFF_MODE_CTRL, 33'h0);
      rd(OFF_WAKE_CAUSE, 33'h80000);
    end
    // brownout in deep-sleep, then reset pin: system reset
    wr(OFF_BOD_CTRL, 32'h2);
    enter(3'h2);
    for (int k = 0; k < 2; k++) begin
      raise(k == 0 ? 5'h16 : 5'h15);
      for (int n = 0; n < 40 && sys_reset_req !== 1'h1; n++) @(posedge pclk);
      check("reset req", 33'h1, 33'(sys_reset_req));
      do_reset();
      check("after reset", 33'h30, 33'({cpu_clk_en, main_clk_en, sys_reset_req, power_state}));
    end
    print_verdict();
  end
endmodule
